// >>> unbs_pkg.sv
// Shared constants, register map and carrier types of the 9-bit serial port with baud selection
package unbs_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [31:0] OFF_SERIAL_CONTROL = 32'h0000_0000;
  localparam logic [31:0] OFF_SERIAL_BUFFER = 32'h0000_0004;
  localparam logic [31:0] OFF_POWER_CONTROL = 32'h0000_0008;
  localparam logic [31:0] OFF_T2_CONTROL = 32'h0000_000C;
  localparam logic [31:0] OFF_T1_RELOAD_HIGH = 32'h0000_0010;
  localparam logic [31:0] OFF_T2_RELOAD_PAIR = 32'h0000_0014;
  localparam logic [31:0] OFF_BAUD_TIMER_CONTROL = 32'h0000_0018;
  localparam logic [31:0] OFF_FRACTIONAL_DIVISOR = 32'h0000_001C;
  localparam logic [31:0] OFF_STATUS = 32'h0000_0020;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_UPPER = 7;
  localparam int CTRL_MODE_LOWER = 6;
  localparam int CTRL_MULTIPROC = 5;
  localparam int CTRL_RX_PERMIT = 4;
  localparam int CTRL_TX_NINTH = 3;
  localparam int CTRL_RX_NINTH = 2;
  localparam int CTRL_TX_DONE = 1;
  localparam int CTRL_RX_DONE = 0;
  localparam int PWR_RATE_DOUBLER = 7;
  localparam int T2C_RX_FROM_T2 = 5;
  localparam int T2C_TX_FROM_T2 = 4;
  localparam int BTC_ENABLE = 7;
  localparam int BTC_PRESCALE_MSB = 2;
  localparam int STAT_TX_BUSY = 1;
  localparam int STAT_RX_BUSY = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_PAIR = 16'h0000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [2:0] M0_HALF_LAST = 3'h5;
  localparam logic [1:0] M2_DIV_SLOW_LAST = 2'h3;
  localparam logic [1:0] M2_DIV_FAST_LAST = 2'h1;
  localparam logic [3:0] T1_PRESCALE_LAST = 4'hB;
  localparam logic [0:0] T2_PRESCALE_LAST = 1'h1;
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [15:0] FRAC_STEP = 16'h0020;
  localparam logic [15:0] FRAC_BASE = 16'h0040;
  localparam logic [3:0] RX_BITS = 4'h9;
  localparam logic [3:0] TX_LEFT_9BIT = 4'hA;
  localparam logic [3:0] TX_LEFT_8BIT = 4'h9;
  localparam logic [3:0] M0_BIT_LAST = 4'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_8BIT = 2'b01,
    MODE_9FIXED = 2'b10,
    MODE_9VAR = 2'b11
  } unbs_mode_t;

  typedef struct packed {
    unbs_mode_t mode;
    logic rate_doubler;
    logic rx_rate_from_t2;
    logic tx_rate_from_t2;
    logic frac_baud_enable;
    logic [2:0] prescale;
    logic [7:0] fractional_divisor;
    logic [7:0] t1_reload_high;
    logic [15:0] t2_reload_pair;
  } unbs_rate_cfg_t;

  typedef struct packed {
    logic tx16;
    logic rx16;
    logic m0_half;
  } unbs_ticks_t;

endpackage

// >>> unbs_frac_timer.sv
// Fractional baud timer producing a 16x oversampling tick stream
`timescale 1ns/1ns
module unbs_frac_timer
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  input wire logic [2:0] prescale,
  input wire logic [7:0] fractional_divisor,
  output logic tick
);
  import unbs_pkg::*;

  logic [15:0] acc_q, acc_d;
  logic tick_q, tick_d;
  logic [15:0] span;
  logic [15:0] sum;

  // Each tick is worth 2^div*(fd+64) phase units, each clock adds 32
  always_comb
  begin
    span = ({8'h00, fractional_divisor} + FRAC_BASE) << prescale;
    sum = acc_q + FRAC_STEP;
    acc_d = sum;
    tick_d = 1'b0;
    if (!enable)
    begin
      acc_d = 16'h0000;
    end
    else if (sum >= span)
    begin
      acc_d = sum - span;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule

// >>> unbs_rate_sel.sv
// Rate timers and per-direction tick selection
`timescale 1ns/1ns
module unbs_rate_sel
(
  input wire logic clock,
  input wire logic nrst,
  input unbs_pkg::unbs_rate_cfg_t cfg,
  input wire logic frac_tick,
  output unbs_pkg::unbs_ticks_t ticks
);
  import unbs_pkg::*;

  logic [2:0] m0_cnt_q, m0_cnt_d;
  logic [1:0] m2_cnt_q, m2_cnt_d;
  logic [3:0] t1_pre_q, t1_pre_d;
  logic [7:0] t1_cnt_q, t1_cnt_d;
  logic t1_half_q, t1_half_d;
  logic [0:0] t2_pre_q, t2_pre_d;
  logic [15:0] t2_cnt_q, t2_cnt_d;
  unbs_ticks_t ticks_q, ticks_d;
  logic m2_tick, t1_tick, t2_tick, t2_run;

  always_comb
  begin
    m0_cnt_d = (m0_cnt_q == M0_HALF_LAST) ? 3'h0 : m0_cnt_q + 3'h1;
    m2_cnt_d = m2_cnt_q + 2'h1;
    m2_tick = (m2_cnt_q == (cfg.rate_doubler ? M2_DIV_FAST_LAST : M2_DIV_SLOW_LAST));
    if (m2_tick)
    begin
      m2_cnt_d = 2'h0;
    end
    // Timer 1: machine-cycle count, 8-bit autoreload
    t1_pre_d = (t1_pre_q == T1_PRESCALE_LAST) ? 4'h0 : t1_pre_q + 4'h1;
    t1_cnt_d = t1_cnt_q;
    t1_half_d = t1_half_q;
    t1_tick = 1'b0;
    if (t1_pre_q == T1_PRESCALE_LAST)
    begin
      t1_cnt_d = (t1_cnt_q == 8'hFF) ? cfg.t1_reload_high : t1_cnt_q + 8'h01;
      if (t1_cnt_q == 8'hFF)
      begin
        t1_half_d = ~t1_half_q;
        t1_tick = cfg.rate_doubler | t1_half_q;
      end
    end
    // Timer 2: counts every two clocks, 16-bit autoreload
    t2_run = cfg.rx_rate_from_t2 | cfg.tx_rate_from_t2;
    t2_pre_d = t2_pre_q;
    t2_cnt_d = t2_cnt_q;
    t2_tick = 1'b0;
    if (t2_run)
    begin
      t2_pre_d = t2_pre_q + 1'h1;
      if (t2_pre_q == T2_PRESCALE_LAST)
      begin
        t2_cnt_d = (t2_cnt_q == 16'hFFFF) ? cfg.t2_reload_pair : t2_cnt_q + 16'h0001;
        t2_tick = (t2_cnt_q == 16'hFFFF);
      end
    end
    else
    begin
      // Stopped timer follows the reload so the first period after a start is full
      t2_cnt_d = cfg.t2_reload_pair;
    end
    ticks_d.m0_half = (m0_cnt_q == M0_HALF_LAST);
    if (cfg.mode == MODE_9FIXED)
    begin
      ticks_d.tx16 = m2_tick;
      ticks_d.rx16 = m2_tick;
    end
    else if (cfg.frac_baud_enable)
    begin
      ticks_d.tx16 = frac_tick;
      ticks_d.rx16 = frac_tick;
    end
    else
    begin
      ticks_d.tx16 = cfg.tx_rate_from_t2 ? t2_tick : t1_tick;
      ticks_d.rx16 = cfg.rx_rate_from_t2 ? t2_tick : t1_tick;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      m0_cnt_q <= 3'h0;
      m2_cnt_q <= 2'h0;
      t1_pre_q <= 4'h0;
      t1_cnt_q <= RST_BYTE;
      t1_half_q <= 1'b0;
      t2_pre_q <= 1'h0;
      t2_cnt_q <= RST_PAIR;
      ticks_q <= '0;
    end
    else
    begin
      m0_cnt_q <= m0_cnt_d;
      m2_cnt_q <= m2_cnt_d;
      t1_pre_q <= t1_pre_d;
      t1_cnt_q <= t1_cnt_d;
      t1_half_q <= t1_half_d;
      t2_pre_q <= t2_pre_d;
      t2_cnt_q <= t2_cnt_d;
      ticks_q <= ticks_d;
    end
  end

  assign ticks = ticks_q;
endmodule

// >>> unbs_top.sv
// Serial port top: AHB-Lite registers, transmit and receive sequencers
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns

module unbs_top
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd
);
  import unbs_pkg::*;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_SHIFT = 2'b10,
    TX_SYNC = 2'b11
  } unbs_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } unbs_rx_state_t;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic dp_wr_q, dp_wr_d, rd_pend_q, rd_pend_d, hready_q, hready_d;
  logic [31:0] dp_addr_q, dp_addr_d, hrdata_q, hrdata_d;
  logic [7:0] ctrl_q, ctrl_d, rxbuf_q, rxbuf_d, t1_rel_q, t1_rel_d, fdiv_q, fdiv_d;
  logic [15:0] t2_rel_q, t2_rel_d;
  logic doubler_q, doubler_d, rx_t2_q, rx_t2_d, tx_t2_q, tx_t2_d, frac_en_q, frac_en_d;
  logic [2:0] prescale_q, prescale_d;
  unbs_tx_state_t tx_state_q, tx_state_d;
  logic [10:0] tsr_q, tsr_d;
  logic [3:0] left_q, left_d, tx_os_q, tx_os_d;
  logic m0_phase_q, m0_phase_d, m0_rx_q, m0_rx_d;
  logic txd_q, txd_d, rxd_out_q, rxd_out_d, rxd_oe_q, rxd_oe_d;
  unbs_rx_state_t rx_state_q, rx_state_d;
  logic [3:0] rx_os_q, rx_os_d, rx_left_q, rx_left_d;
  logic [8:0] rsr_q, rsr_d;
  logic rxd_prev_q, rxd_prev_d;
  logic ap_valid, wr_en, tx_start, bit_edge, ev_tx_done, ev_m0_rx, ev_rx_store, rx_ninth_ev;
  logic [7:0] m0_byte;
  unbs_mode_t mode;
  unbs_rate_cfg_t cfg;
  unbs_ticks_t ticks;
  logic frac_tick;

  function automatic logic hits(input logic [31:0] addr, input logic [31:0] off);
    hits = (addr == off);
  endfunction

  // ----------------------------------------------------------------
  // Rate generation
  // ----------------------------------------------------------------
  always_comb
  begin
    cfg.mode = mode;
    cfg.rate_doubler = doubler_q;
    cfg.rx_rate_from_t2 = rx_t2_q;
    cfg.tx_rate_from_t2 = tx_t2_q;
    cfg.frac_baud_enable = frac_en_q;
    cfg.prescale = prescale_q;
    cfg.fractional_divisor = fdiv_q;
    cfg.t1_reload_high = t1_rel_q;
    cfg.t2_reload_pair = t2_rel_q;
  end

  unbs_frac_timer u_frac
  (
    .clock(clock),
    .nrst(nrst),
    .enable(frac_en_q),
    .prescale(prescale_q),
    .fractional_divisor(fdiv_q),
    .tick(frac_tick)
  );

  unbs_rate_sel u_rate
  (
    .clock(clock),
    .nrst(nrst),
    .cfg(cfg),
    .frac_tick(frac_tick),
    .ticks(ticks)
  );

  // ----------------------------------------------------------------
  // Bus slave and register file
  // ----------------------------------------------------------------
  assign mode = unbs_mode_t'({ctrl_q[CTRL_MODE_UPPER], ctrl_q[CTRL_MODE_LOWER]});
  assign ap_valid = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
  assign wr_en = dp_wr_q;
  assign tx_start = wr_en && hits(dp_addr_q, OFF_SERIAL_BUFFER);

  always_comb
  begin
    dp_wr_d = ap_valid && hwrite;
    rd_pend_d = ap_valid && !hwrite;
    dp_addr_d = ap_valid ? haddr : dp_addr_q;
    // Reads take one wait state so they see writes of the previous data phase
    hready_d = !(ap_valid && !hwrite);
    hrdata_d = hrdata_q;
    if (rd_pend_q)
    begin
      hrdata_d = 32'h0000_0000;
      if (hits(dp_addr_q, OFF_SERIAL_CONTROL)) hrdata_d[7:0] = ctrl_q;
      if (hits(dp_addr_q, OFF_SERIAL_BUFFER)) hrdata_d[7:0] = rxbuf_q;
      if (hits(dp_addr_q, OFF_POWER_CONTROL)) hrdata_d[PWR_RATE_DOUBLER] = doubler_q;
      if (hits(dp_addr_q, OFF_T2_CONTROL))
      begin
        hrdata_d[T2C_RX_FROM_T2] = rx_t2_q;
        hrdata_d[T2C_TX_FROM_T2] = tx_t2_q;
      end
      if (hits(dp_addr_q, OFF_T1_RELOAD_HIGH)) hrdata_d[7:0] = t1_rel_q;
      if (hits(dp_addr_q, OFF_T2_RELOAD_PAIR)) hrdata_d[15:0] = t2_rel_q;
      if (hits(dp_addr_q, OFF_BAUD_TIMER_CONTROL))
      begin
        hrdata_d[BTC_ENABLE] = frac_en_q;
        hrdata_d[BTC_PRESCALE_MSB:0] = prescale_q;
      end
      if (hits(dp_addr_q, OFF_FRACTIONAL_DIVISOR)) hrdata_d[7:0] = fdiv_q;
      if (hits(dp_addr_q, OFF_STATUS))
      begin
        hrdata_d[STAT_TX_BUSY] = (tx_state_q != TX_IDLE);
        hrdata_d[STAT_RX_BUSY] = (rx_state_q != RX_IDLE) || (tx_state_q == TX_SYNC && m0_rx_q);
      end
    end
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    doubler_d = doubler_q;
    rx_t2_d = rx_t2_q;
    tx_t2_d = tx_t2_q;
    t1_rel_d = t1_rel_q;
    t2_rel_d = t2_rel_q;
    frac_en_d = frac_en_q;
    prescale_d = prescale_q;
    fdiv_d = fdiv_q;
    rxbuf_d = rxbuf_q;
    if (wr_en)
    begin
      if (hits(dp_addr_q, OFF_SERIAL_CONTROL)) ctrl_d = hwdata[7:0];
      if (hits(dp_addr_q, OFF_POWER_CONTROL)) doubler_d = hwdata[PWR_RATE_DOUBLER];
      if (hits(dp_addr_q, OFF_T2_CONTROL))
      begin
        rx_t2_d = hwdata[T2C_RX_FROM_T2];
        tx_t2_d = hwdata[T2C_TX_FROM_T2];
      end
      if (hits(dp_addr_q, OFF_T1_RELOAD_HIGH)) t1_rel_d = hwdata[7:0];
      if (hits(dp_addr_q, OFF_T2_RELOAD_PAIR)) t2_rel_d = hwdata[15:0];
      if (hits(dp_addr_q, OFF_BAUD_TIMER_CONTROL))
      begin
        frac_en_d = hwdata[BTC_ENABLE];
        prescale_d = hwdata[BTC_PRESCALE_MSB:0];
      end
      if (hits(dp_addr_q, OFF_FRACTIONAL_DIVISOR)) fdiv_d = hwdata[7:0];
    end
    // Hardware sets win over a software clear in the same cycle
    if (ev_tx_done) ctrl_d[CTRL_TX_DONE] = 1'b1;
    if (ev_rx_store)
    begin
      ctrl_d[CTRL_RX_DONE] = 1'b1;
      ctrl_d[CTRL_RX_NINTH] = ev_m0_rx ? ctrl_q[CTRL_RX_NINTH] : rx_ninth_ev;
      rxbuf_d = ev_m0_rx ? m0_byte : rsr_q[8:1];
    end
  end

  // ----------------------------------------------------------------
  // Transmit sequencer, also runs shift register mode
  // ----------------------------------------------------------------
  always_comb
  begin
    tx_state_d = tx_state_q;
    tsr_d = tsr_q;
    left_d = left_q;
    tx_os_d = ticks.tx16 ? tx_os_q + 4'h1 : tx_os_q;
    m0_phase_d = m0_phase_q;
    m0_rx_d = m0_rx_q;
    txd_d = txd_q;
    rxd_out_d = rxd_out_q;
    rxd_oe_d = rxd_oe_q;
    ev_tx_done = 1'b0;
    ev_m0_rx = 1'b0;
    m0_byte = {rxd_in, tsr_q[7:1]};
    bit_edge = ticks.tx16 && (tx_os_q == OS_LAST);
    if (tx_start)
    begin
      left_d = 4'h0;
      if (mode == MODE_SHIFT)
      begin
        tx_state_d = TX_SYNC;
        tsr_d = {3'b111, hwdata[7:0]};
        m0_rx_d = 1'b0;
        m0_phase_d = 1'b0;
        rxd_oe_d = 1'b1;
        rxd_out_d = hwdata[0];
        txd_d = 1'b1;
      end
      else
      begin
        tx_state_d = TX_WAIT;
        tsr_d = {1'b1, (mode == MODE_8BIT) ? 1'b1 : ctrl_q[CTRL_TX_NINTH], hwdata[7:0], 1'b0};
      end
    end
    else
    begin
      unique case (tx_state_q)
        TX_IDLE:
        begin
          if (mode == MODE_SHIFT && ctrl_q[CTRL_RX_PERMIT] && !ctrl_q[CTRL_RX_DONE])
          begin
            tx_state_d = TX_SYNC;
            m0_rx_d = 1'b1;
            m0_phase_d = 1'b0;
            left_d = 4'h0;
            rxd_oe_d = 1'b0;
          end
        end
        TX_WAIT:
        begin
          if (bit_edge)
          begin
            txd_d = tsr_q[0];
            tsr_d = {1'b1, tsr_q[10:1]};
            left_d = (mode == MODE_8BIT) ? TX_LEFT_8BIT : TX_LEFT_9BIT;
            tx_state_d = TX_SHIFT;
          end
        end
        TX_SHIFT:
        begin
          if (bit_edge)
          begin
            if (left_q == 4'h0)
            begin
              tx_state_d = TX_IDLE;
            end
            else
            begin
              txd_d = tsr_q[0];
              tsr_d = {1'b1, tsr_q[10:1]};
              left_d = left_q - 4'h1;
              ev_tx_done = (left_q == 4'h1);
            end
          end
        end
        TX_SYNC:
        begin
          if (ticks.m0_half)
          begin
            m0_phase_d = ~m0_phase_q;
            txd_d = m0_phase_q;
            if (m0_phase_q)
            begin
              left_d = left_q + 4'h1;
              tsr_d[7:0] = m0_rx_q ? m0_byte : {1'b1, tsr_q[7:1]};
              rxd_out_d = tsr_q[1];
              if (left_q == M0_BIT_LAST)
              begin
                tx_state_d = TX_IDLE;
                rxd_oe_d = 1'b0;
                ev_m0_rx = m0_rx_q;
                ev_tx_done = !m0_rx_q;
              end
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive sequencer for framed modes
  // ----------------------------------------------------------------
  always_comb
  begin
    rx_state_d = rx_state_q;
    rx_os_d = ticks.rx16 ? rx_os_q + 4'h1 : rx_os_q;
    rx_left_d = rx_left_q;
    rsr_d = rsr_q;
    rxd_prev_d = rxd_in;
    ev_rx_store = ev_m0_rx;
    rx_ninth_ev = rxd_in;
    unique case (rx_state_q)
      RX_IDLE:
      begin
        rx_os_d = 4'h0;
        if (mode != MODE_SHIFT && ctrl_q[CTRL_RX_PERMIT] && rxd_prev_q && !rxd_in)
        begin
          rx_state_d = RX_START;
        end
      end
      RX_START:
      begin
        // Start bit re-checked at mid-bit to reject glitches
        if (ticks.rx16 && rx_os_q == OS_MID)
        begin
          rx_os_d = 4'h0;
          rx_left_d = RX_BITS;
          rx_state_d = rxd_in ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA:
      begin
        if (ticks.rx16 && rx_os_q == OS_LAST)
        begin
          rsr_d = {rxd_in, rsr_q[8:1]};
          rx_left_d = rx_left_q - 4'h1;
          if (rx_left_q == 4'h1)
          begin
            rx_state_d = RX_STOP;
            ev_rx_store = !ctrl_q[CTRL_RX_DONE] && (!ctrl_q[CTRL_MULTIPROC] || rxd_in);
          end
        end
      end
      RX_STOP:
      begin
        if (rxd_in)
        begin
          rx_state_d = RX_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dp_wr_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hready_q <= 1'b1;
      dp_addr_q <= 32'h0000_0000;
      hrdata_q <= 32'h0000_0000;
      ctrl_q <= RST_BYTE;
      rxbuf_q <= RST_BYTE;
      doubler_q <= 1'b0;
      rx_t2_q <= 1'b0;
      tx_t2_q <= 1'b0;
      t1_rel_q <= RST_BYTE;
      t2_rel_q <= RST_PAIR;
      frac_en_q <= 1'b0;
      prescale_q <= 3'h0;
      fdiv_q <= RST_BYTE;
      tx_state_q <= TX_IDLE;
      tsr_q <= 11'h7FF;
      left_q <= 4'h0;
      tx_os_q <= 4'h0;
      m0_phase_q <= 1'b0;
      m0_rx_q <= 1'b0;
      txd_q <= 1'b1;
      rxd_out_q <= 1'b1;
      rxd_oe_q <= 1'b0;
      rx_state_q <= RX_IDLE;
      rx_os_q <= 4'h0;
      rx_left_q <= 4'h0;
      rsr_q <= 9'h000;
      rxd_prev_q <= 1'b1;
    end
    else
    begin
      dp_wr_q <= dp_wr_d;
      rd_pend_q <= rd_pend_d;
      hready_q <= hready_d;
      dp_addr_q <= dp_addr_d;
      hrdata_q <= hrdata_d;
      ctrl_q <= ctrl_d;
      rxbuf_q <= rxbuf_d;
      doubler_q <= doubler_d;
      rx_t2_q <= rx_t2_d;
      tx_t2_q <= tx_t2_d;
      t1_rel_q <= t1_rel_d;
      t2_rel_q <= t2_rel_d;
      frac_en_q <= frac_en_d;
      prescale_q <= prescale_d;
      fdiv_q <= fdiv_d;
      tx_state_q <= tx_state_d;
      tsr_q <= tsr_d;
      left_q <= left_d;
      tx_os_q <= tx_os_d;
      m0_phase_q <= m0_phase_d;
      m0_rx_q <= m0_rx_d;
      txd_q <= txd_d;
      rxd_out_q <= rxd_out_d;
      rxd_oe_q <= rxd_oe_d;
      rx_state_q <= rx_state_d;
      rx_os_q <= rx_os_d;
      rx_left_q <= rx_left_d;
      rsr_q <= rsr_d;
      rxd_prev_q <= rxd_prev_d;
    end
  end

  assign hreadyout = hready_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign txd = txd_q;
  assign rxd_out = rxd_out_q;
  assign rxd_oe = rxd_oe_q;
endmodule

// >>> unbs_checker.sv
// Bus and serial line assertions for the serial port
`timescale 1ns/1ns
module unbs_checker
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic rxd_oe,
  input wire logic txd
);
  import unbs_pkg::*;
  logic rd;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  assign rd = hsel && hready && htrans[1] && !hwrite && hsize == HSIZE_WORD;
  hresp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
  read_wait_a: assert property (rd |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  no_wait_a: assert property (!rd |=> hreadyout) else $error("unexpected wait");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("hrdata changed");
  upper_zero_a: assert property (hrdata[31:16] == 16'h0000) else $error("upper bits set");
  txd_low_a: assert property ($fell(txd) |-> !txd [*6]) else $error("txd low too short");
  txd_high_a: assert property ($rose(txd) |-> txd [*6]) else $error("txd high too short");
  reset_idle_a: assert property ($rose(nrst) |-> txd && !rxd_oe && hreadyout)
    else $error("not idle after reset");
  cover property (rd);
  cover property ($fell(txd));
  cover property ($rose(hreadyout));
endmodule
bind unbs_top unbs_checker u_unbs_checker (.clock(clock), .nrst(nrst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .rxd_oe(rxd_oe), .txd(txd));

// >>> unbs_remote.sv
// Remote asynchronous transceiver on the serial lines
`timescale 1ns/1ns
module unbs_remote
(
  input wire logic clock,
  input wire logic txd,
  output logic rxd_in
);
  initial rxd_in = 1'b1;
  // Start low, data LSB first, ninth, stop high
  task automatic send(input logic [8:0] v, input int per);
    logic [10:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rxd_in <= f[i];
      repeat (per) @(posedge clock);
    end
  endtask
  // Mid-bit sampling; unknown result on timeout
  task automatic recv(input int per, output logic [9:0] v);
    int n;
    n = 0;
    v = 'x;
    while (txd !== 1'b0 && n < 20000)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 20000)
      return;
    repeat (per / 2) @(posedge clock);
    for (int i = 0; i < 10; i++)
    begin
      repeat (per) @(posedge clock);
      v[i] = txd;
    end
  endtask
endmodule

// >>> tb_uart_nine_bit_baud_select.sv
// Testbench for the 9-bit serial port with baud selection
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_uart_nine_bit_baud_select;
  import unbs_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, rxd_in, rxd_out, rxd_oe, txd;
  logic [31:0] hrdata, rd;
  logic [9:0] fr;
  int bad_count = 0;
  int total_checks = 0;
  initial forever #5 clock = ~clock;
  unbs_top u_unbs_top (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
  unbs_remote u_unbs_remote (.clock(clock), .txd(txd), .rxd_in(rxd_in));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        bad_count++;
        print_verdict();
      end
      @(posedge clock);
    end
  endtask
  // One single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic tx_frame(input logic [7:0] b, input int per, input logic [9:0] e);
    bus(1, OFF_SERIAL_BUFFER, {24'h0, b});
    u_unbs_remote.recv(per, fr);
    `CHK("tx frame", e, fr);
    // A timed-out frame is already counted; stop before the next long wait
    if ($isunknown(fr)) print_verdict();
  endtask
  task automatic regs_case;
    bus(0, OFF_BAUD_TIMER_CONTROL, 0);
    `CHK("baud_timer_control", 32'h0000_0000, rd);
    bus(1, OFF_BAUD_TIMER_CONTROL, 32'h0000_00FF);
    bus(0, OFF_BAUD_TIMER_CONTROL, 0);
    `CHK("baud_timer_control", 32'h0000_0087, rd);
    bus(1, OFF_BAUD_TIMER_CONTROL, 0);
    bus(0, 32'h0000_0040, 0);
    `CHK("unmapped", 32'h0000_0000, rd);
  endtask
  // Mode 0 transmit: data bit is read while the shift clock is low
  task automatic mode0_tx;
    logic [7:0] s;
    int n;
    s = '0;
    bus(1, OFF_SERIAL_BUFFER, 32'h0000_0096);
    for (int i = 0; i < 16; i++)
    begin
      n = 0;
      do
      begin
        @(posedge clock);
        n++;
      end
      while (txd !== i[0] && n < 50);
      if (n >= 50)
      begin
        bad_count++;
        print_verdict();
      end
      if (i == 0) `CHK("m0 oe", 1'b1, rxd_oe);
      if (!i[0]) s[i / 2] = rxd_out;
    end
    `CHK("m0 data", 8'h96, s);
    bus(0, OFF_SERIAL_CONTROL, 0);
    `CHK("m0 tx done", 32'h0000_0002, rd);
  endtask
  task automatic mode2_tx;
    bus(1, OFF_SERIAL_CONTROL, 32'h0000_0088);
    tx_frame(8'hA5, 64, 10'h3A5);
    bus(0, OFF_SERIAL_CONTROL, 0);
    `CHK("tx done", 32'h0000_008A, rd);
  endtask
  task automatic mode2_rx;
    bus(1, OFF_POWER_CONTROL, 32'h0000_0080);
    bus(1, OFF_SERIAL_CONTROL, 32'h0000_0090);
    u_unbs_remote.send(9'h13C, 32);
    bus(0, OFF_SERIAL_BUFFER, 0);
    `CHK("rx buffer", 32'h0000_003C, rd);
    bus(0, OFF_SERIAL_CONTROL, 0);
    `CHK("rx flags", 32'h0000_0095, rd);
  endtask
  task automatic multiproc_case;
    bus(1, OFF_SERIAL_CONTROL, 32'h0000_00B0);
    u_unbs_remote.send(9'h055, 32);
    bus(0, OFF_SERIAL_CONTROL, 0);
    `CHK("discard", 32'h0000_00B0, rd);
    u_unbs_remote.send(9'h1C3, 32);
    bus(0, OFF_SERIAL_CONTROL, 0);
    `CHK("accept", 32'h0000_00B5, rd);
    u_unbs_remote.send(9'h1AA, 32);
    bus(0, OFF_SERIAL_BUFFER, 0);
    `CHK("overrun kept", 32'h0000_00C3, rd);
  endtask
  task automatic var_rates;
    bus(1, OFF_SERIAL_CONTROL, 32'h0000_00D8);
    bus(1, OFF_T2_CONTROL, 32'h0000_0030);
    for (int p = 0; p < 2; p++)
    begin
      bus(1, OFF_BAUD_TIMER_CONTROL, 32'h0000_0080 | p);
      tx_frame(8'h5A, 32 << p, 10'h35A);
    end
    bus(1, OFF_BAUD_TIMER_CONTROL, 0);
    // Timer 2 stopped while the reload is set, so it restarts from the new value
    bus(1, OFF_T2_CONTROL, 0);
    bus(1, OFF_T2_RELOAD_PAIR, 32'h0000_FFFE);
    bus(1, OFF_T2_CONTROL, 32'h0000_0010);
    tx_frame(8'h81, 64, 10'h381);
    bus(1, OFF_T2_CONTROL, 32'h0000_0020);
    bus(1, OFF_T2_RELOAD_PAIR, 32'h0000_FFFF);
    bus(1, OFF_T1_RELOAD_HIGH, 32'h0000_00FF);
    tx_frame(8'h3C, 192, 10'h33C);
    u_unbs_remote.send(9'h1E7, 32);
    bus(0, OFF_SERIAL_BUFFER, 0);
    `CHK("t2 rx buffer", 32'h0000_00E7, rd);
  endtask
  initial
  begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    regs_case();
    mode0_tx();
    mode2_tx();
    mode2_rx();
    multiproc_case();
    var_rates();
    print_verdict();
  end
endmodule
